/* aesdc_pkg.sv */
// package of constants, types and helpers for the cipher block datapath control
// assumes a single clock domain and an external cipher core streaming bytes
// Functional notes
// [RQ1] two low bits of block config choose key length 128, 192 or 256 bits
// [RQ2] key length code 00=128, 01=192, 10=256; code 11 reserved
// [RQ3] block config bit 2 set means encrypt, cleared means decrypt
// [RQ4] setting block config bit 3 enables and starts a new operation
// [RQ5] block config bit 5 sets when a whole block result is ready
// [RQ6] datapath config bits 0 to 2 pick the input and output mux setup
// [RQ7] datapath value 0x04 routes the core key output to the result register
// [RQ8] datapath value 0x00 routes core data straight out, no xor anywhere
// [RQ9] input mux feeds block byte alone or block byte xor operand byte
// [RQ10] output picks core data, core key, or core data xor operand
// [RQ11] host interleaves input xor bytes; output xor bytes come after completion
// [RQ12] key output gives the inverse key of the chosen direction
// [RQ13] host writes block byte, optional xor byte, key byte, sixteen times
// [RQ14] sequencer requests input bytes, then output bytes after completion
// [RQ15] sequencer steps on each input byte written and each result read
// [RQ16] clearing enable returns the sequencer to its start state
// [RQ17] consecutive blocks run without disabling between them
// [RQ18] host writes sixteen filler block bytes for key inversion
// [RQ19] host alternates filler and key bytes, then the extra key bytes
// [RQ20] longer keys come out as bytes 16-23, 24-31, then 0-15
// [RQ21] every transfer is one byte; first processed byte is index zero
// [RQ22] key, block and output request streams issue in the required order
// [RQ23] host sets datapath config before starting an operation
// [RQ24] dma users rely on dma completion rather than the done flag
// [RQ25] host writes 0x00 to block config, configures, then sets enable
// [RQ26] reads after completion return result or key bytes in output order
// [RQ27] writing enable clears done; done holds until cleared or disabled
package aesdc_pkg;

  // ----------------------------------------------------------------
  // register selects
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_BLOCK_CFG = 3'h0;
  localparam logic [2:0] SEL_DATAPATH_CFG = 3'h1;
  localparam logic [2:0] SEL_BLOCK_IN = 3'h2;
  localparam logic [2:0] SEL_XOR_IN = 3'h3;
  localparam logic [2:0] SEL_KEY_IN = 3'h4;
  localparam logic [2:0] SEL_RESULT = 3'h5;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int BCFG_KSIZE_LSB = 0;
  localparam int BCFG_DIR_BIT = 2;
  localparam int BCFG_EN_BIT = 3;
  localparam int BCFG_DONE_BIT = 5;
  localparam logic [7:0] BCFG_RESET = 8'h00;
  localparam logic [2:0] DCFG_RESET = 3'h0;
  localparam logic [7:0] XOR_RESET = 8'h00;

  localparam logic [2:0] DCFG_DIRECT = 3'h0;
  localparam logic [2:0] DCFG_IN_XOR = 3'h1;
  localparam logic [2:0] DCFG_OUT_XOR = 3'h2;
  localparam logic [2:0] DCFG_KEY_OUT = 3'h4;

  localparam logic [1:0] KSZ_128 = 2'h0;
  localparam logic [1:0] KSZ_192 = 2'h1;
  localparam logic [1:0] KSZ_256 = 2'h2;

  // ----------------------------------------------------------------
  // byte counts
  // ----------------------------------------------------------------
  localparam logic [5:0] BLOCK_BYTES = 6'h10;
  localparam logic [5:0] KEY_BYTES_192 = 6'h18;
  localparam logic [5:0] KEY_BYTES_256 = 6'h20;
  localparam logic [5:0] EXT_BYTES_192 = 6'h08;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    AESDC_IDLE = 2'b00,
    AESDC_LOAD = 2'b01,
    AESDC_RUN = 2'b10,
    AESDC_UNLOAD = 2'b11
  } aesdc_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] sel;
    logic [7:0] wdata;
  } aesdc_bus_t;

  typedef struct packed {
    logic blk_valid;
    logic [7:0] blk;
    logic key_valid;
    logic [7:0] key;
    logic start;
    logic [1:0] key_size;
    logic encrypt;
  } aesdc_core_in_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic [7:0] key;
  } aesdc_core_res_t;

  typedef struct packed {
    logic key;
    logic block;
    logic out;
  } aesdc_dma_req_t;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // reserved code 11 falls back to the short key
  function automatic logic [5:0] aesdc_key_len(input logic [1:0] ksz);
    case (ksz)
      KSZ_192: aesdc_key_len = KEY_BYTES_192;
      KSZ_256: aesdc_key_len = KEY_BYTES_256;
      default: aesdc_key_len = BLOCK_BYTES;
    endcase
  endfunction : aesdc_key_len

  // storage index of the n-th byte to leave in key output mode
  function automatic logic [4:0] aesdc_key_order(input logic [1:0] ksz, input logic [5:0] n);
    logic [5:0] idx;
    idx = n;
    case (ksz)
      KSZ_192: idx = (n < EXT_BYTES_192) ? n + BLOCK_BYTES : n - EXT_BYTES_192;
      KSZ_256: idx = (n < BLOCK_BYTES) ? n + BLOCK_BYTES : n - BLOCK_BYTES;
      default: idx = n;
    endcase
    aesdc_key_order = idx[4:0];
  endfunction : aesdc_key_order

endpackage : aesdc_pkg

/* aesdc_byte_mem.sv */
// result byte store: one write port, one read port with registered data
// assumes addresses are in range; contents are not cleared by reset
`timescale 1ns/10ps
`default_nettype none
module aesdc_byte_mem (
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [4:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [4:0] raddr,
  output logic [7:0] rdata
);

  logic [7:0] mem [0:31];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule : aesdc_byte_mem
`default_nettype wire

/* aesdc_top.sv */
// byte sequencer, configuration registers and in/out muxes around a cipher core
// assumes the core takes bytes on valid strobes and returns its result as a byte stream
`timescale 1ns/10ps
`default_nettype none
module aesdc_top (
  input wire logic clk,
  input wire logic rst,
  input wire aesdc_pkg::aesdc_bus_t bus,
  output logic [7:0] rdata,
  output aesdc_pkg::aesdc_core_in_t core_in,
  input wire aesdc_pkg::aesdc_core_res_t core_res,
  output aesdc_pkg::aesdc_dma_req_t dma_req,
  output logic done_flag
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  aesdc_pkg::aesdc_state_t state;
  logic [1:0] key_size;
  logic encrypt;
  logic enable;
  logic done;
  logic [2:0] dcfg;
  logic [7:0] xor_reg;
  logic [5:0] blk_cnt;
  logic [5:0] key_cnt;
  logic [5:0] res_cnt;
  logic [5:0] out_cnt;
  logic xor_pend;
  logic [7:0] blk_hold;
  logic settle;
  logic blk_valid;
  logic [7:0] blk_byte;
  logic key_valid;
  logic [7:0] key_byte;
  logic start_q;
  logic [7:0] mem_q;
  logic [4:0] mem_raddr;

  logic wr_bcfg;
  logic wr_dcfg;
  logic wr_blk;
  logic wr_xor;
  logic wr_key;
  logic rd_res;
  logic next_enable;
  logic key_mode;
  logic in_xor;
  logic [5:0] klen;
  logic [5:0] out_total;
  logic take_blk;
  logic take_xor;
  logic take_key;
  logic take_out;
  logic load_full;
  logic res_last;
  logic out_last;
  logic out_ok;
  logic [7:0] out_byte;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign wr_bcfg = bus.wr && (bus.sel == aesdc_pkg::SEL_BLOCK_CFG);
  assign wr_dcfg = bus.wr && (bus.sel == aesdc_pkg::SEL_DATAPATH_CFG);
  assign wr_blk = bus.wr && (bus.sel == aesdc_pkg::SEL_BLOCK_IN);
  assign wr_xor = bus.wr && (bus.sel == aesdc_pkg::SEL_XOR_IN);
  assign wr_key = bus.wr && (bus.sel == aesdc_pkg::SEL_KEY_IN);
  assign rd_res = bus.rd && (bus.sel == aesdc_pkg::SEL_RESULT);
  assign next_enable = wr_bcfg ? bus.wdata[aesdc_pkg::BCFG_EN_BIT] : enable;

  assign key_mode = (dcfg == aesdc_pkg::DCFG_KEY_OUT); // RQ6
  assign in_xor = (dcfg == aesdc_pkg::DCFG_IN_XOR); // RQ6
  assign klen = aesdc_pkg::aesdc_key_len(key_size); // RQ1 RQ2
  assign out_total = key_mode ? klen : aesdc_pkg::BLOCK_BYTES;

  // block byte, then optional xor byte, then key byte per position
  assign take_blk = wr_blk && (state == aesdc_pkg::AESDC_LOAD) && (blk_cnt < aesdc_pkg::BLOCK_BYTES)
                    && (key_cnt == blk_cnt) && !xor_pend; // RQ15
  assign take_xor = wr_xor && (state == aesdc_pkg::AESDC_LOAD) && xor_pend; // RQ9
  assign take_key = wr_key && (state == aesdc_pkg::AESDC_LOAD) && !xor_pend
                    && ((key_cnt < blk_cnt) || ((blk_cnt == aesdc_pkg::BLOCK_BYTES) && (key_cnt < klen))); // RQ15
  assign load_full = (state == aesdc_pkg::AESDC_LOAD) && (blk_cnt == aesdc_pkg::BLOCK_BYTES)
                     && (key_cnt == klen);
  assign res_last = (state == aesdc_pkg::AESDC_RUN) && core_res.valid && (res_cnt == out_total - 6'h01);
  assign out_ok = (state == aesdc_pkg::AESDC_UNLOAD) && !settle;
  assign take_out = rd_res && out_ok; // RQ15
  assign out_last = take_out && (out_cnt == out_total - 6'h01);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      key_size <= aesdc_pkg::BCFG_RESET[1:0];
      encrypt <= aesdc_pkg::BCFG_RESET[aesdc_pkg::BCFG_DIR_BIT];
      enable <= aesdc_pkg::BCFG_RESET[aesdc_pkg::BCFG_EN_BIT];
    end else if (wr_bcfg) begin
      key_size <= bus.wdata[aesdc_pkg::BCFG_KSIZE_LSB +: 2]; // RQ1
      encrypt <= bus.wdata[aesdc_pkg::BCFG_DIR_BIT]; // RQ3
      enable <= bus.wdata[aesdc_pkg::BCFG_EN_BIT]; // RQ4
    end
  end

  // any write to block config clears done; a finishing block in the same cycle wins unless the write clears enable
  always_ff @(posedge clk) begin
    if (rst) begin
      done <= 1'b0;
    end else if (!next_enable) begin
      done <= 1'b0; // RQ27
    end else if (res_last) begin
      done <= 1'b1; // RQ5
    end else if (wr_bcfg) begin
      done <= 1'b0; // RQ27
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dcfg <= aesdc_pkg::DCFG_RESET;
    end else if (wr_dcfg) begin
      dcfg <= bus.wdata[2:0]; // RQ6
    end
  end

  // the operand is kept so output xor bytes written after completion apply at read
  always_ff @(posedge clk) begin
    if (rst) begin
      xor_reg <= aesdc_pkg::XOR_RESET;
    end else if (wr_xor) begin
      xor_reg <= bus.wdata;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= aesdc_pkg::AESDC_IDLE;
    end else if (!next_enable) begin
      state <= aesdc_pkg::AESDC_IDLE; // RQ16
    end else begin
      case (state)
        aesdc_pkg::AESDC_IDLE: state <= aesdc_pkg::AESDC_LOAD; // RQ4
        aesdc_pkg::AESDC_LOAD: state <= load_full ? aesdc_pkg::AESDC_RUN : aesdc_pkg::AESDC_LOAD;
        aesdc_pkg::AESDC_RUN: state <= res_last ? aesdc_pkg::AESDC_UNLOAD : aesdc_pkg::AESDC_RUN;
        aesdc_pkg::AESDC_UNLOAD: state <= out_last ? aesdc_pkg::AESDC_LOAD : aesdc_pkg::AESDC_UNLOAD; // RQ17
        default: state <= aesdc_pkg::AESDC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !next_enable || load_full) begin
      blk_cnt <= 6'h00; // RQ16
    end else if (take_blk) begin
      blk_cnt <= blk_cnt + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !next_enable || load_full) begin
      key_cnt <= 6'h00;
    end else if (take_key) begin
      key_cnt <= key_cnt + 6'h01;
    end
  end

  // in input xor mode the block byte waits for its operand
  always_ff @(posedge clk) begin
    if (rst || !next_enable) begin
      xor_pend <= 1'b0;
      blk_hold <= 8'h00;
    end else if (take_blk && in_xor) begin
      xor_pend <= 1'b1;
      blk_hold <= bus.wdata;
    end else if (take_xor) begin
      xor_pend <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !next_enable || res_last) begin
      res_cnt <= 6'h00;
    end else if ((state == aesdc_pkg::AESDC_RUN) && core_res.valid) begin
      res_cnt <= res_cnt + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !next_enable || out_last) begin
      out_cnt <= 6'h00;
    end else if (take_out) begin
      out_cnt <= out_cnt + 6'h01; // RQ26
    end
  end

  // memory read data lags the pointer by one cycle, so hold off after each move
  always_ff @(posedge clk) begin
    if (rst) begin
      settle <= 1'b1;
    end else begin
      settle <= take_out || (state != aesdc_pkg::AESDC_UNLOAD);
    end
  end

  // ----------------------------------------------------------------
  // core feed
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      blk_valid <= 1'b0;
      blk_byte <= 8'h00;
    end else begin
      blk_valid <= (take_blk && !in_xor) || take_xor;
      if (take_xor) begin
        blk_byte <= blk_hold ^ bus.wdata; // RQ9
      end else if (take_blk && !in_xor) begin
        blk_byte <= bus.wdata; // RQ9 RQ21
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      key_valid <= 1'b0;
      key_byte <= 8'h00;
    end else begin
      key_valid <= take_key;
      if (take_key) begin
        key_byte <= bus.wdata; // RQ21
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      start_q <= 1'b0;
    end else begin
      start_q <= load_full && next_enable; // RQ4
    end
  end

  // the core returns the inverse key for its set direction on core_res.key
  assign core_in = '{blk_valid: blk_valid, blk: blk_byte, key_valid: key_valid, key: key_byte,
                     start: start_q, key_size: key_size, encrypt: encrypt}; // RQ3 RQ12

  // ----------------------------------------------------------------
  // result store and output mux
  // ----------------------------------------------------------------
  assign mem_raddr = key_mode ? aesdc_pkg::aesdc_key_order(key_size, out_cnt) : out_cnt[4:0]; // RQ20

  aesdc_byte_mem u_mem (
    .clk(clk),
    .rst(rst),
    .we((state == aesdc_pkg::AESDC_RUN) && core_res.valid),
    .waddr(res_cnt[4:0]),
    .wdata(key_mode ? core_res.key : core_res.data), // RQ7 RQ12
    .raddr(mem_raddr),
    .rdata(mem_q)
  );

  always_comb begin
    case (dcfg)
      aesdc_pkg::DCFG_KEY_OUT: out_byte = mem_q; // RQ7 RQ10
      aesdc_pkg::DCFG_OUT_XOR: out_byte = mem_q ^ xor_reg; // RQ10
      default: out_byte = mem_q; // RQ8
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      case (bus.sel)
        aesdc_pkg::SEL_BLOCK_CFG: rdata <= {2'b00, done, 1'b0, enable, encrypt, key_size};
        aesdc_pkg::SEL_DATAPATH_CFG: rdata <= {5'b00000, dcfg};
        aesdc_pkg::SEL_RESULT: rdata <= out_ok ? out_byte : 8'h00; // RQ26
        default: rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // dma requests: key and block interleave, output only after completion
  // ----------------------------------------------------------------
  always_comb begin
    dma_req.block = (state == aesdc_pkg::AESDC_LOAD) && (blk_cnt < aesdc_pkg::BLOCK_BYTES)
                    && (key_cnt == blk_cnt) && !xor_pend; // RQ14 RQ22
    dma_req.key = (state == aesdc_pkg::AESDC_LOAD) && !xor_pend
                  && ((key_cnt < blk_cnt) || ((blk_cnt == aesdc_pkg::BLOCK_BYTES) && (key_cnt < klen))); // RQ22
    dma_req.out = out_ok; // RQ14
  end

  assign done_flag = done;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_load_full;
    (state == aesdc_pkg::AESDC_LOAD) && (blk_cnt == aesdc_pkg::BLOCK_BYTES) && (key_cnt == klen) && next_enable;
  endsequence

  sequence s_started;
    start_q && (state == aesdc_pkg::AESDC_RUN) && (blk_cnt == 6'h00);
  endsequence

  a_start_full: assert property (@(posedge clk) disable iff (rst) s_load_full |=> s_started) // RQ4
    else $error("start did not follow a full load");

  a_disable_idle: assert property (@(posedge clk) disable iff (rst)
    (wr_bcfg && !bus.wdata[aesdc_pkg::BCFG_EN_BIT]) |=> (state == aesdc_pkg::AESDC_IDLE) && !done
    && (blk_cnt == 6'h00) && (key_cnt == 6'h00)) // RQ16
    else $error("disable did not reset the sequencer");

  a_done_set: assert property (@(posedge clk) disable iff (rst)
    (res_last && next_enable) |=> done && (state == aesdc_pkg::AESDC_UNLOAD) ##1 (out_ok || !enable)) // RQ5
    else $error("done or unload missing after last result byte");

  a_done_clear: assert property (@(posedge clk) disable iff (rst)
    (wr_bcfg && !res_last) |=> !done) // RQ27
    else $error("done not cleared by config write");

  a_key_out: assert property (@(posedge clk) disable iff (rst)
    (take_out && key_mode) |=> (rdata == $past(mem_q))) // RQ7
    else $error("key output mux wrong");

  a_direct_out: assert property (@(posedge clk) disable iff (rst)
    (take_out && (dcfg == aesdc_pkg::DCFG_DIRECT)) |=> (rdata == $past(mem_q))) // RQ8
    else $error("direct output mux wrong");

  a_xor_out: assert property (@(posedge clk) disable iff (rst)
    (take_out && (dcfg == aesdc_pkg::DCFG_OUT_XOR)) |=> (rdata == ($past(mem_q) ^ $past(xor_reg)))) // RQ10
    else $error("output xor mux wrong");

  a_xor_in: assert property (@(posedge clk) disable iff (rst)
    take_xor |=> blk_valid && (blk_byte == ($past(blk_hold) ^ $past(bus.wdata)))) // RQ9
    else $error("input xor byte wrong");

  a_req_order: assert property (@(posedge clk) disable iff (rst)
    !(dma_req.block && dma_req.key) && !(dma_req.out && (dma_req.block || dma_req.key))) // RQ22
    else $error("request streams overlap");

  a_key_first: assert property (@(posedge clk) disable iff (rst)
    (key_mode && (key_size == aesdc_pkg::KSZ_192) && (out_cnt == 6'h00)) |-> (mem_raddr == 5'h10)) // RQ20
    else $error("extended key byte order wrong");

endmodule : aesdc_top
`default_nettype wire

/* aesdc_core_model.sv */
// behavioural cipher core facing the datapath control block
// assumes one start pulse per block; key_mode tells it how many bytes to return
`timescale 1ns/10ps
`default_nettype none
module aesdc_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire aesdc_pkg::aesdc_core_in_t core_in,
  input wire logic key_mode,
  input wire logic slow,
  output var aesdc_pkg::aesdc_core_res_t core_res
);
  logic [7:0] blk_q [0:15];
  logic [7:0] key_q [0:31];
  logic [3:0] bi;
  logic [4:0] ki;
  logic [5:0] left;
  logic [5:0] oi;
  logic gap;
  logic enc;

  // ----------------------------------------------------------------
  // byte capture and result stream
  // ----------------------------------------------------------------
  // fixed byte mapping stands in for the rounds; key output is the bitwise inverse
  always_ff @(posedge clk) begin
    if (rst) begin
      bi <= 4'h0;
      ki <= 5'h00;
      left <= 6'h00;
      oi <= 6'h00;
      gap <= 1'b0;
      enc <= 1'b0;
      core_res <= '0;
    end else begin
      core_res.valid <= 1'b0;
      gap <= ~gap;
      if (core_in.blk_valid) begin
        blk_q[bi] <= core_in.blk;
        bi <= bi + 4'h1;
      end
      if (core_in.key_valid) begin
        key_q[ki] <= core_in.key;
        ki <= ki + 5'h01;
      end
      if (core_in.start) begin
        left <= !key_mode ? 6'h10 : (core_in.key_size == 2'h1) ? 6'h18 : (core_in.key_size == 2'h2) ? 6'h20 : 6'h10;
        enc <= core_in.encrypt;
        oi <= 6'h00;
        bi <= 4'h0;
        ki <= 5'h00;
      end else if (left != 6'h00 && (!slow || gap)) begin
        core_res.valid <= 1'b1;
        core_res.data <= blk_q[oi[3:0]] ^ (enc ? 8'h3c : 8'hc3);
        core_res.key <= ~key_q[oi[4:0]];
        oi <= oi + 6'h01;
        left <= left - 6'h01;
      end else begin
        // idle lines toggle so a stale byte is never mistaken for a fresh one
        core_res.data <= ~core_res.data;
        core_res.key <= ~core_res.key;
      end
    end
  end
endmodule : aesdc_core_model
`default_nettype wire

/* aesdc_top_tb.sv */
// self-checking bench: register accesses by byte, core model on the far side
// assumes the select codes and field positions of the design package
`timescale 1ns/10ps
`default_nettype none
module aesdc_top_tb;
  logic clk;
  logic rst;
  logic key_mode;
  logic slow;
  logic flush;
  aesdc_pkg::aesdc_bus_t bus;
  logic [7:0] rdata;
  aesdc_pkg::aesdc_core_in_t core_in;
  aesdc_pkg::aesdc_core_res_t core_res;
  aesdc_pkg::aesdc_dma_req_t dma_req;
  logic done_flag;
  int fail_count;
  int samples_checked;
  int cycles;
  logic [7:0] got;

  aesdc_top u_aesdc_top (
    .clk(clk),
    .rst(rst),
    .bus(bus),
    .rdata(rdata),
    .core_in(core_in),
    .core_res(core_res),
    .dma_req(dma_req),
    .done_flag(done_flag)
  );

  // core is cleared by reset and by flush, which the bench pulses only after the aborted load
  aesdc_core_model u_aesdc_core_model (
    .clk(clk),
    .rst(rst || flush),
    .core_in(core_in),
    .key_mode(key_mode),
    .slow(slow),
    .core_res(core_res)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // register access, entered and left just after a rising edge
  // ----------------------------------------------------------------
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    bus.sel = s;
    bus.wdata = d;
    bus.wr = 1'b1;
    @(posedge clk);
    #1 bus.wr = 1'b0;
    @(posedge clk);
    #1;
  endtask : wr

  // two cycles per read also keeps the result reads spaced as required
  task automatic rd(input logic [2:0] s, output logic [7:0] d);
    bus.sel = s;
    bus.rd = 1'b1;
    @(posedge clk);
    #1 bus.rd = 1'b0;
    d = rdata;
    @(posedge clk);
    #1;
  endtask : rd

  // ----------------------------------------------------------------
  // one block: configure, load, wait, unload and compare
  // ----------------------------------------------------------------
  task automatic run(input logic [2:0] dc, input logic [1:0] ksz, input logic enc, input logic fresh,
                     input logic slw);
    int nk;
    int nout;
    logic [7:0] cfg;
    logic [7:0] e;
    logic [7:0] xo;
    cfg = {4'h0, 1'b1, enc, ksz};
    nk = (ksz == 2'h1) ? 24 : (ksz == 2'h2) ? 32 : 16;
    key_mode = (dc == aesdc_pkg::DCFG_KEY_OUT);
    slow = slw;
    xo = 8'h5a;
    if (fresh) begin
      wr(aesdc_pkg::SEL_BLOCK_CFG, 8'h00);
      check("done after clear", {7'h0, done_flag}, 8'h00);
      wr(aesdc_pkg::SEL_DATAPATH_CFG, {5'h00, dc});
    end
    wr(aesdc_pkg::SEL_BLOCK_CFG, cfg);
    check("done after enable", {7'h0, done_flag}, 8'h00);
    rd(aesdc_pkg::SEL_BLOCK_CFG, got);
    check("block config", got, cfg);
    check("key size", {6'h00, core_in.key_size}, {6'h00, ksz});
    check("direction", {7'h0, core_in.encrypt}, {7'h0, enc});
    rd(aesdc_pkg::SEL_RESULT, got);
    check("early result", got, 8'h00);
    // key byte out of turn must not advance the sequence
    wr(aesdc_pkg::SEL_KEY_IN, 8'hee);
    check("block request", {7'h0, dma_req.block}, 8'h01);
    for (int i = 0; i < 16; i++) begin
      wr(aesdc_pkg::SEL_BLOCK_IN, 8'(8'h10 + i));
      // in input xor mode the key waits for the host-written operand, so nothing is requested
      if (i == 0) check("key request", {5'h00, dma_req}, (dc == aesdc_pkg::DCFG_IN_XOR) ? 8'h00 : 8'h04);
      if (dc == aesdc_pkg::DCFG_IN_XOR) wr(aesdc_pkg::SEL_XOR_IN, 8'(8'h40 + i));
      wr(aesdc_pkg::SEL_KEY_IN, 8'(8'h80 + i));
    end
    for (int i = 16; i < nk; i++) wr(aesdc_pkg::SEL_KEY_IN, 8'(8'h80 + i));
    for (int w = 0; w < 300 && done_flag !== 1'b1; w++) begin
      @(posedge clk);
      #1;
    end
    check("done flag", {7'h0, done_flag}, 8'h01);
    rd(aesdc_pkg::SEL_BLOCK_CFG, got);
    check("done bit", got, cfg | 8'h20);
    check("output request", {7'h0, dma_req.out}, 8'h01);
    if (dc == aesdc_pkg::DCFG_OUT_XOR) wr(aesdc_pkg::SEL_XOR_IN, xo);
    nout = key_mode ? nk : 16;
    for (int n = 0; n < nout; n++) begin
      rd(aesdc_pkg::SEL_RESULT, got);
      if (key_mode) begin
        e = 8'(nk == 16 ? n : (n < nk - 16) ? n + 16 : n - (nk - 16));
        e = ~(8'h80 + e);
        check("key out", got, e);
      end else begin
        e = 8'(8'h10 + n) ^ (enc ? 8'h3c : 8'hc3);
        if (dc == aesdc_pkg::DCFG_IN_XOR) e = e ^ 8'(8'h40 + n);
        if (dc == aesdc_pkg::DCFG_OUT_XOR) e = e ^ xo;
        check("data out", got, e);
      end
    end
    check("done held", {7'h0, done_flag}, 8'h01);
    check("next block request", {5'h00, dma_req}, 8'h02);
  endtask : run

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    bus = '0;
    key_mode = 1'b0;
    slow = 1'b0;
    flush = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    rd(aesdc_pkg::SEL_BLOCK_CFG, got);
    check("block config reset", got, aesdc_pkg::BCFG_RESET);
    rd(aesdc_pkg::SEL_DATAPATH_CFG, got);
    check("datapath reset", got, 8'h00);
    rd(3'h6, got);
    check("unmapped", got, 8'h00);
    wr(aesdc_pkg::SEL_BLOCK_CFG, 8'hd3);
    rd(aesdc_pkg::SEL_BLOCK_CFG, got);
    check("unused bits", got, 8'h03);
    run(3'h0, 2'h0, 1'b1, 1'b1, 1'b0);
    run(3'h0, 2'h0, 1'b0, 1'b0, 1'b1);
    run(3'h1, 2'h1, 1'b0, 1'b1, 1'b0);
    run(3'h2, 2'h2, 1'b1, 1'b1, 1'b1);
    run(3'h4, 2'h0, 1'b1, 1'b1, 1'b0);
    run(3'h4, 2'h1, 1'b1, 1'b1, 1'b1);
    run(3'h4, 2'h2, 1'b0, 1'b1, 1'b0);
    // abort part way through a load, then a clean block must follow
    wr(aesdc_pkg::SEL_BLOCK_CFG, 8'h0c);
    wr(aesdc_pkg::SEL_BLOCK_IN, 8'h77);
    wr(aesdc_pkg::SEL_KEY_IN, 8'h66);
    wr(aesdc_pkg::SEL_BLOCK_IN, 8'h55);
    wr(aesdc_pkg::SEL_BLOCK_CFG, 8'h00);
    flush = 1'b1;
    check("requests after disable", {5'h00, dma_req}, 8'h00);
    @(posedge clk);
    #1 flush = 1'b0;
    run(3'h0, 2'h3, 1'b1, 1'b1, 1'b0);
    wrap_up();
  end
endmodule : aesdc_top_tb
`default_nettype wire
